// ===== hw/rtcc_pkg.sv
// constants and types for the reload timer with capture
// assumes one system clock; register offsets are special-function-register addresses
package rtcc_pkg;
    // -------------------------------------------------------------------------
    // register addresses
    // -------------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'hC0;
    localparam logic [7:0] ADDR_CLKSEL = 8'hC1;
    localparam logic [7:0] ADDR_RLD_LO = 8'hCA;
    localparam logic [7:0] ADDR_RLD_HI = 8'hCB;
    localparam logic [7:0] ADDR_CNT_LO = 8'hCC;
    localparam logic [7:0] ADDR_CNT_HI = 8'hCD;
    // -------------------------------------------------------------------------
    // fields, reset values, counts
    // -------------------------------------------------------------------------
    localparam int CLKSEL_LO_POS = 4;
    localparam int CLKSEL_HI_POS = 5;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CLKSEL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [2:0] REF_DIV_LAST = 3'h7;

    typedef struct packed {
        logic hof;      // high_overflow_flag
        logic lof;      // low_overflow_flag
        logic lof_ie;   // low-byte interrupt enable, stored only
        logic cap_en;   // capture_enable
        logic split;    // split_mode
        logic run;      // run_control
        logic ref_sel;  // reference_select
        logic ext_sel;  // external_select
    } rtcc_ctrl_t;
endpackage : rtcc_pkg

// ===== hw/rtcc_ref_tick.sv
// synchroniser and divide-by-eight for one reference oscillator
// assumes the reference is far slower than the system clock
`timescale 1ns/1ns
module rtcc_ref_tick (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ref,
    output logic o_tick
);
    logic sync0_r;
    logic sync1_r;
    logic prev_r;
    logic [2:0] edge_cnt_r;
    logic rise;

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync0_r <= 1'b0;
            sync1_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync0_r <= i_ref;
            sync1_r <= sync0_r;
            prev_r <= sync1_r;
        end
    end

    assign rise = sync1_r & ~prev_r;

    // one pulse per eighth rising edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            edge_cnt_r <= 3'h0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= rise && (edge_cnt_r == rtcc_pkg::REF_DIV_LAST);
            if (rise) begin
                edge_cnt_r <= edge_cnt_r + 3'h1;
            end
        end
    end
endmodule : rtcc_ref_tick

// ===== hw/rtcc_timer.sv
// auto-reload timer, 16-bit or split 8-bit, with reference capture
// assumes an sfr bus synchronous to i_clk; write takes effect at the next edge
`timescale 1ns/1ns

module rtcc_timer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_ext_osc,
    input wire logic i_rtc_osc,
    output logic [7:0] o_sfr_rdata,
    output logic o_high_overflow,
    output logic o_low_overflow
);
    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    rtcc_pkg::rtcc_ctrl_t ctrl_r;
    logic [7:0] clksel_r;
    logic [7:0] rld_lo_r;
    logic [7:0] rld_hi_r;
    logic [7:0] cnt_lo_r;
    logic [7:0] cnt_hi_r;
    logic [7:0] cnt_lo_nxt;
    logic [7:0] cnt_hi_nxt;
    logic [3:0] div12_r;
    logic [7:0] rdata_r;
    logic div12_tick;
    logic ext8;
    logic rtc8;
    logic ref_cnt_tick;
    logic alt_tick;
    logic lo_tick;
    logic hi_tick;
    logic lo_en;
    logic hi_en;
    logic lo_wrap;
    logic hi_wrap;
    logic wrap16;
    logic cap_ev;
    logic wr_ctrl;
    logic wr_clksel;
    logic wr_rld_lo;
    logic wr_rld_hi;
    logic wr_cnt_lo;
    logic wr_cnt_hi;

    // -------------------------------------------------------------------------
    // clock sources
    // -------------------------------------------------------------------------
    rtcc_ref_tick u_ext_tick (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ref(i_ext_osc),
        .o_tick(ext8)
    );

    rtcc_ref_tick u_rtc_tick (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ref(i_rtc_osc),
        .o_tick(rtc8)
    );

    // free-running prescaler, never reset by writes so tick spacing stays exact
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div12_r <= 4'h0;
        end else if (div12_r == rtcc_pkg::DIV12_LAST) begin
            div12_r <= 4'h0;
        end else begin
            div12_r <= div12_r + 4'h1;
        end
    end

    assign div12_tick = (div12_r == rtcc_pkg::DIV12_LAST);
    assign ref_cnt_tick = ctrl_r.ref_sel ? rtc8 : ext8;
    assign alt_tick = ctrl_r.ext_sel ? ref_cnt_tick : div12_tick;
    assign lo_tick = clksel_r[rtcc_pkg::CLKSEL_LO_POS] ? 1'b1 : alt_tick;
    assign hi_tick = clksel_r[rtcc_pkg::CLKSEL_HI_POS] ? 1'b1 : alt_tick;
    assign cap_ev = ctrl_r.cap_en && (ctrl_r.ref_sel ? ext8 : rtc8);

    // -------------------------------------------------------------------------
    // count path
    // -------------------------------------------------------------------------
    assign lo_en = ctrl_r.split ? lo_tick : (ctrl_r.run && lo_tick);
    assign hi_en = ctrl_r.split && ctrl_r.run && hi_tick;
    assign lo_wrap = lo_en && (cnt_lo_r == rtcc_pkg::BYTE_MAX);
    assign hi_wrap = hi_en && (cnt_hi_r == rtcc_pkg::BYTE_MAX);
    assign wrap16 = !ctrl_r.split && lo_wrap && (cnt_hi_r == rtcc_pkg::BYTE_MAX);

    assign wr_ctrl = i_sfr_wr && (i_sfr_addr == rtcc_pkg::ADDR_CTRL);
    assign wr_clksel = i_sfr_wr && (i_sfr_addr == rtcc_pkg::ADDR_CLKSEL);
    assign wr_rld_lo = i_sfr_wr && (i_sfr_addr == rtcc_pkg::ADDR_RLD_LO);
    assign wr_rld_hi = i_sfr_wr && (i_sfr_addr == rtcc_pkg::ADDR_RLD_HI);
    assign wr_cnt_lo = i_sfr_wr && (i_sfr_addr == rtcc_pkg::ADDR_CNT_LO);
    assign wr_cnt_hi = i_sfr_wr && (i_sfr_addr == rtcc_pkg::ADDR_CNT_HI);

    always_comb begin
        cnt_lo_nxt = cnt_lo_r;
        cnt_hi_nxt = cnt_hi_r;
        if (ctrl_r.split) begin
            if (lo_wrap) begin
                cnt_lo_nxt = rld_lo_r;
            end else if (lo_en) begin
                cnt_lo_nxt = cnt_lo_r + 8'h01;
            end
            if (hi_wrap) begin
                cnt_hi_nxt = rld_hi_r;
            end else if (hi_en) begin
                cnt_hi_nxt = cnt_hi_r + 8'h01;
            end
        end else if (wrap16) begin
            cnt_lo_nxt = rld_lo_r;
            cnt_hi_nxt = rld_hi_r;
        end else if (lo_en) begin
            {cnt_hi_nxt, cnt_lo_nxt} = {cnt_hi_r, cnt_lo_r} + 16'h0001;
        end
    end

    // software write to a count byte overrides the increment
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_lo_r <= rtcc_pkg::BYTE_RST;
            cnt_hi_r <= rtcc_pkg::BYTE_RST;
        end else begin
            cnt_lo_r <= wr_cnt_lo ? i_sfr_wdata : cnt_lo_nxt;
            cnt_hi_r <= wr_cnt_hi ? i_sfr_wdata : cnt_hi_nxt;
        end
    end

    // capture wins over a software write in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rld_lo_r <= rtcc_pkg::BYTE_RST;
            rld_hi_r <= rtcc_pkg::BYTE_RST;
        end else if (cap_ev) begin
            rld_lo_r <= cnt_lo_r;
            rld_hi_r <= cnt_hi_r;
        end else begin
            if (wr_rld_lo) begin
                rld_lo_r <= i_sfr_wdata;
            end
            if (wr_rld_hi) begin
                rld_hi_r <= i_sfr_wdata;
            end
        end
    end

    // -------------------------------------------------------------------------
    // control and flags
    // -------------------------------------------------------------------------
    // a hardware set in the same cycle as a software clear keeps the flag set
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= rtcc_pkg::CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= i_sfr_wdata;
            end
            ctrl_r.hof <= (wr_ctrl ? i_sfr_wdata[7] : ctrl_r.hof) | wrap16 | hi_wrap | cap_ev;
            ctrl_r.lof <= (wr_ctrl ? i_sfr_wdata[6] : ctrl_r.lof) | lo_wrap;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clksel_r <= rtcc_pkg::CLKSEL_RST;
        end else if (wr_clksel) begin
            clksel_r <= i_sfr_wdata;
        end
    end

    // -------------------------------------------------------------------------
    // read port
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= rtcc_pkg::BYTE_RST;
        end else begin
            case (i_sfr_addr)
                rtcc_pkg::ADDR_CTRL: rdata_r <= ctrl_r;
                rtcc_pkg::ADDR_CLKSEL: rdata_r <= clksel_r;
                rtcc_pkg::ADDR_RLD_LO: rdata_r <= rld_lo_r;
                rtcc_pkg::ADDR_RLD_HI: rdata_r <= rld_hi_r;
                rtcc_pkg::ADDR_CNT_LO: rdata_r <= cnt_lo_r;
                rtcc_pkg::ADDR_CNT_HI: rdata_r <= cnt_hi_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign o_sfr_rdata = rdata_r;
    assign o_high_overflow = ctrl_r.hof;
    assign o_low_overflow = ctrl_r.lof;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence div_gap_s;
        (!div12_tick) [*8] ##1 (!div12_tick) [*3];
    endsequence

    sequence cap_done_s;
        ({rld_hi_r, rld_lo_r} == $past({cnt_hi_r, cnt_lo_r})) && ctrl_r.hof;
    endsequence

    capture_copy_a: assert property (cap_ev |=> cap_done_s)
        else $error("capture did not copy count and set high flag");
    capture_source_a: assert property (ctrl_r.cap_en && ctrl_r.ref_sel && ext8 && !wr_ctrl |=> ctrl_r.hof)
        else $error("external capture did not set high flag");
    capture_off_a: assert property (!ctrl_r.cap_en && !wr_rld_lo && !wr_rld_hi |=> $stable(rld_lo_r))
        else $error("reload changed with capture off");
    split_low_run_a: assert property (ctrl_r.split && lo_tick && !i_sfr_wr && cnt_lo_r != 8'hFF
        |=> cnt_lo_r == $past(cnt_lo_r) + 8'h01)
        else $error("split low byte did not count");
    stop16_hold_a: assert property (!ctrl_r.split && !ctrl_r.run && !i_sfr_wr
        |=> $stable({cnt_hi_r, cnt_lo_r}))
        else $error("stopped 16-bit timer changed");
    wrap16_reload_a: assert property (!ctrl_r.split && ctrl_r.run && lo_tick && {cnt_hi_r, cnt_lo_r} == 16'hFFFF
        && !i_sfr_wr |=> {cnt_hi_r, cnt_lo_r} == $past({rld_hi_r, rld_lo_r}) && ctrl_r.hof)
        else $error("16-bit wrap did not reload");
    split_high_wrap_a: assert property (ctrl_r.split && ctrl_r.run && hi_tick && cnt_hi_r == 8'hFF
        && !i_sfr_wr |=> cnt_hi_r == $past(rld_hi_r) && ctrl_r.hof)
        else $error("split high byte did not reload");
    flag_sticky_a: assert property (ctrl_r.hof && !wr_ctrl |=> ctrl_r.hof)
        else $error("high flag cleared by hardware");
    system_clock_select_a: assert property (clksel_r[rtcc_pkg::CLKSEL_LO_POS] && !ctrl_r.split && ctrl_r.run && !i_sfr_wr
        && {cnt_hi_r, cnt_lo_r} != 16'hFFFF
        |=> {cnt_hi_r, cnt_lo_r} == $past({cnt_hi_r, cnt_lo_r}) + 16'h0001)
        else $error("system clock select did not step every cycle");
    div12_period_a: assert property (div12_tick && !ctrl_r.ext_sel && !clksel_r[rtcc_pkg::CLKSEL_LO_POS]
        |-> lo_tick ##1 div_gap_s ##1 div12_tick)
        else $error("divide-by-12 spacing wrong");
    ref_count_a: assert property (ctrl_r.ext_sel && !clksel_r[rtcc_pkg::CLKSEL_LO_POS] && !ctrl_r.ref_sel
        && !ctrl_r.split && ctrl_r.run && !ext8 && !i_sfr_wr |=> $stable(cnt_lo_r))
        else $error("count moved without external reference tick");
endmodule : rtcc_timer

// ===== testbench/rtcc_timer_tb.sv
// self-checking bench for the reload timer with capture
// assumes the design under hw/ is compiled first; bench drives the sfr bus and both oscillators
`timescale 1ns/1ns
module rtcc_timer_tb;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00;
    logic i_sfr_wr = 1'b0;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic i_ext_osc = 1'b0;
    logic i_rtc_osc = 1'b0;
    logic [7:0] o_sfr_rdata;
    logic o_high_overflow;
    logic o_low_overflow;
    int bad_count = 0;
    int cmp_count = 0;
    logic [7:0] rd;

    always #2 i_clk = ~i_clk;

    rtcc_timer dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
        .i_sfr_wdata(i_sfr_wdata), .i_ext_osc(i_ext_osc), .i_rtc_osc(i_rtc_osc), .o_sfr_rdata(o_sfr_rdata),
        .o_high_overflow(o_high_overflow), .o_low_overflow(o_low_overflow));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        check({7'h00, (v >= lo) && (v <= hi)}, 8'h01);
    endtask : in_range

    task automatic idle(input int n);
        repeat (n) @(negedge i_clk);
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        @(negedge i_clk);
        i_sfr_wr = 1'b0;
    endtask : wr

    // address held two edges, so registered read data has settled
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        i_sfr_addr = a;
        idle(2);
        d = o_sfr_rdata;
    endtask : reg_rd

    // rise counts kept at multiples of eight so the reference dividers stay aligned
    task automatic pulses(input int ne, input int nr);
        for (int i = 0; i < ((ne > nr) ? ne : nr); i++) begin
            @(negedge i_clk);
            i_ext_osc = (i < ne);
            i_rtc_osc = (i < nr);
            idle(3);
            i_ext_osc = 1'b0;
            i_rtc_osc = 1'b0;
            idle(3);
        end
        idle(8);
    endtask : pulses

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] addrs [7] = '{8'hC0, 8'hC1, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC7};
        foreach (addrs[i]) begin
            reg_rd(addrs[i], rd);
            check(rd, 8'h00);
        end
        wr(rtcc_pkg::ADDR_RLD_LO, 8'h5A);
        wr(8'hC7, 8'hFF);
        reg_rd(rtcc_pkg::ADDR_RLD_LO, rd);
        check(rd, 8'h5A);
        reg_rd(8'hC7, rd);
        check(rd, 8'h00);
    endtask : t_regs

    task automatic t_wrap();
        wr(rtcc_pkg::ADDR_RLD_LO, 8'h00);
        wr(rtcc_pkg::ADDR_RLD_HI, 8'h12);
        wr(rtcc_pkg::ADDR_CNT_LO, 8'hFE);
        wr(rtcc_pkg::ADDR_CNT_HI, 8'hFF);
        wr(rtcc_pkg::ADDR_CLKSEL, 8'h10);
        wr(rtcc_pkg::ADDR_CTRL, 8'h04);
        idle(20);
        check({7'h00, o_high_overflow}, 8'h01);
        check({7'h00, o_low_overflow}, 8'h01);
        wr(rtcc_pkg::ADDR_CTRL, 8'h00);
        idle(2);
        check({6'h00, o_high_overflow, o_low_overflow}, 8'h00);
        reg_rd(rtcc_pkg::ADDR_CNT_HI, rd);
        check(rd, 8'h12);
    endtask : t_wrap

    task automatic t_prescale();
        wr(rtcc_pkg::ADDR_CNT_LO, 8'h00);
        wr(rtcc_pkg::ADDR_CLKSEL, 8'h00);
        wr(rtcc_pkg::ADDR_CTRL, 8'h04);
        idle(120);
        wr(rtcc_pkg::ADDR_CTRL, 8'h00);
        reg_rd(rtcc_pkg::ADDR_CNT_LO, rd);
        in_range(rd, 8'h09, 8'h0B);
    endtask : t_prescale

    task automatic t_ref_count();
        wr(rtcc_pkg::ADDR_CNT_LO, 8'h00);
        wr(rtcc_pkg::ADDR_CTRL, 8'h05);
        pulses(16, 8);
        reg_rd(rtcc_pkg::ADDR_CNT_LO, rd);
        check(rd, 8'h02);
        wr(rtcc_pkg::ADDR_CTRL, 8'h07);
        wr(rtcc_pkg::ADDR_CNT_LO, 8'h00);
        pulses(8, 16);
        reg_rd(rtcc_pkg::ADDR_CNT_LO, rd);
        check(rd, 8'h02);
        check({7'h00, o_high_overflow}, 8'h00);
        wr(rtcc_pkg::ADDR_CTRL, 8'h00);
    endtask : t_ref_count

    // low byte on system clock, high byte on system_clock/12 and gated by run, then high byte on system clock
    task automatic t_split();
        wr(rtcc_pkg::ADDR_CNT_LO, 8'hF0);
        wr(rtcc_pkg::ADDR_CNT_HI, 8'h05);
        wr(rtcc_pkg::ADDR_CLKSEL, 8'h10);
        wr(rtcc_pkg::ADDR_CTRL, 8'h08);
        idle(24);
        check({6'h00, o_high_overflow, o_low_overflow}, 8'h01);
        reg_rd(rtcc_pkg::ADDR_CNT_HI, rd);
        check(rd, 8'h05);
        wr(rtcc_pkg::ADDR_CTRL, 8'h0C);
        idle(120);
        wr(rtcc_pkg::ADDR_CTRL, 8'h08);
        reg_rd(rtcc_pkg::ADDR_CNT_HI, rd);
        in_range(rd, 8'h0E, 8'h10);
        wr(rtcc_pkg::ADDR_CNT_HI, 8'hF8);
        wr(rtcc_pkg::ADDR_CLKSEL, 8'h20);
        wr(rtcc_pkg::ADDR_CTRL, 8'h0C);
        idle(18);
        check({7'h00, o_high_overflow}, 8'h01);
        wr(rtcc_pkg::ADDR_CTRL, 8'h08);
        reg_rd(rtcc_pkg::ADDR_CNT_HI, rd);
        check(rd, 8'h1E);
        wr(rtcc_pkg::ADDR_CTRL, 8'h00);
    endtask : t_split

    task automatic t_capture();
        wr(rtcc_pkg::ADDR_CNT_HI, 8'hAB);
        wr(rtcc_pkg::ADDR_CNT_LO, 8'hCD);
        wr(rtcc_pkg::ADDR_CTRL, 8'h12);
        pulses(8, 0);
        check({7'h00, o_high_overflow}, 8'h01);
        reg_rd(rtcc_pkg::ADDR_RLD_LO, rd);
        check(rd, 8'hCD);
        reg_rd(rtcc_pkg::ADDR_RLD_HI, rd);
        check(rd, 8'hAB);
        wr(rtcc_pkg::ADDR_CTRL, 8'h10);
        wr(rtcc_pkg::ADDR_CNT_LO, 8'h11);
        pulses(8, 0);
        check({7'h00, o_high_overflow}, 8'h00);
        pulses(0, 8);
        check({7'h00, o_high_overflow}, 8'h01);
        reg_rd(rtcc_pkg::ADDR_RLD_LO, rd);
        check(rd, 8'h11);
        wr(rtcc_pkg::ADDR_CTRL, 8'h00);
        wr(rtcc_pkg::ADDR_CNT_LO, 8'h22);
        pulses(8, 8);
        check({7'h00, o_high_overflow}, 8'h00);
        reg_rd(rtcc_pkg::ADDR_RLD_LO, rd);
        check(rd, 8'h11);
    endtask : t_capture

    // mid-run reset with flags set and non-zero count and reload
    task automatic t_reset();
        wr(rtcc_pkg::ADDR_CTRL, 8'hC0);
        i_rst_n = 1'b0;
        idle(3);
        check({6'h00, o_high_overflow, o_low_overflow}, 8'h00);
        i_rst_n = 1'b1;
        reg_rd(rtcc_pkg::ADDR_CNT_HI, rd);
        check(rd, 8'h00);
        reg_rd(rtcc_pkg::ADDR_RLD_LO, rd);
        check(rd, 8'h00);
    endtask : t_reset

    // ------------------------------------------------------------------
    // verdict and run control
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        idle(3);
        i_rst_n = 1'b1;
        t_regs();
        t_wrap();
        t_prescale();
        t_ref_count();
        t_split();
        t_capture();
        t_reset();
        report_and_stop();
    end

    // whole sequence needs under a thousand cycles; generous margin
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        report_and_stop();
    end
endmodule : rtcc_timer_tb
